/* src/mpb_pkg.sv */
// What this block does
// - names ending in _n are asserted low, every other signal is asserted high.
// - read_not_write is high for reads from an external device and low for writes to it.
// - byte_write_enable_n bit 0 qualifies data bits 7:0, bit 1 qualifies data bits 15:8.
// - a 22-bit address leaves on dedicated pins; bits 25:22 appear only where their alt function is on.
// - the data bus is 16 bits both ways: the port drives it on writes, the selected device on reads.
// - while cold reset is asserted the data pins are inputs and their levels become the boot vector.
// - six low-active chip selects each pick one external device during a transaction.
// - bus_grant_n is asserted only after the port has released the bus.
// - read_output_enable_n is asserted while the selected device is expected to drive data.
// - buffer_direction_n follows the transfer direction for the external transceiver.
// - buffer_output_enable_n enables the external transceiver during a transfer.
// - bus operations are timed from the master clock and a clock at a quarter of its rate goes out to devices.
// - cold reset initialises state and loads the boot vector.
// - warm_reset_n starts a warm reset when pulled low outside and is driven low during any warm reset.
package mpb_pkg;
  localparam int ADDR_W = 22;
  localparam int ADDR_HI_W = 4;
  localparam int DATA_W = 16;
  localparam int CS_W = 6;
  localparam int BE_W = 2;
  localparam int CS_IDX_W = 3;
  // bus phase lengths in master-clock cycles
  localparam logic [3:0] SETUP_CYC = 4'h1;
  localparam logic [3:0] STROBE_CYC = 4'h2;
  localparam logic [3:0] HOLD_CYC = 4'h1;
  // warm reset drive length in cycles
  localparam logic [7:0] WARM_CYC = 8'h10;
  // bus clock divider: toggle every this many cycles plus one
  localparam logic [1:0] CLK_DIV = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_STROBE = 3'h3,
    ST_HOLD = 3'h2,
    ST_RELEASE = 3'h6,
    ST_GRANTED = 3'h7
  } mpb_state_t;
endpackage : mpb_pkg

/* src/mpb_sync.sv */
`timescale 1ns/100ps
// two-flop synchroniser for pins coming from outside the clock domain
module mpb_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_q <= RESET_VAL;
      syncOut <= RESET_VAL;
    end else begin
      meta_q <= pinIn;
      syncOut <= meta_q;
    end
  end
endmodule : mpb_sync

/* src/mpb_bus_port.sv */
`timescale 1ns/100ps
// memory and peripheral bus port: one transfer at a time, with bus hand-over
module mpb_bus_port #(
  // phase lengths in master-clock cycles; the defaults give a four-cycle transfer
  parameter logic [3:0] SETUP_LEN = mpb_pkg::SETUP_CYC,
  parameter logic [3:0] STROBE_LEN = mpb_pkg::STROBE_CYC,
  parameter logic [3:0] HOLD_LEN = mpb_pkg::HOLD_CYC,
  parameter logic [7:0] WARM_LEN = mpb_pkg::WARM_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  // cold reset pin and warm reset line
  input wire logic cold_reset_n,
  input wire logic warmResetIn_n,
  output logic warmResetOut,
  output logic warmResetOe,
  input wire logic warmResetReq,
  output logic warmResetActive,
  // internal request side
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqRead,
  input wire logic [mpb_pkg::ADDR_W+mpb_pkg::ADDR_HI_W-1:0] reqAddr,
  input wire logic [mpb_pkg::CS_IDX_W-1:0] reqCs,
  input wire logic [mpb_pkg::BE_W-1:0] reqByteEn,
  input wire logic [mpb_pkg::DATA_W-1:0] reqWData,
  output logic rspValid,
  output logic [mpb_pkg::DATA_W-1:0] rspRData,
  input wire logic [mpb_pkg::ADDR_HI_W-1:0] addrHiAltEn,
  output logic [mpb_pkg::DATA_W-1:0] bootVector,
  output logic bootValid,
  // bus pins
  output logic bus_clock_out,
  output logic [mpb_pkg::ADDR_W-1:0] bus_address,
  output logic [mpb_pkg::ADDR_HI_W-1:0] busAddrHi,
  output logic [mpb_pkg::ADDR_HI_W-1:0] busAddrHiOe,
  output logic busAddrOe,
  input wire logic [mpb_pkg::DATA_W-1:0] busDataIn,
  output logic [mpb_pkg::DATA_W-1:0] busDataOut,
  output logic busDataOe,
  output logic [mpb_pkg::CS_W-1:0] chip_select_n,
  output logic read_not_write,
  output logic [mpb_pkg::BE_W-1:0] byte_write_enable_n,
  output logic read_output_enable_n,
  output logic buffer_direction_n,
  output logic buffer_output_enable_n,
  output logic strobeOe,
  input wire logic bus_request_n,
  output logic bus_grant_n
);
  typedef struct packed {
    mpb_pkg::mpb_state_t st;
    logic [3:0] cnt;
    logic rd;
    logic [mpb_pkg::ADDR_W+mpb_pkg::ADDR_HI_W-1:0] addr;
    logic [mpb_pkg::CS_W-1:0] cs;
    logic [mpb_pkg::BE_W-1:0] be;
    logic [mpb_pkg::DATA_W-1:0] wdata;
    logic [mpb_pkg::DATA_W-1:0] rdata;
    logic rspV;
    logic [mpb_pkg::DATA_W-1:0] boot;
    logic bootV;
    logic coldSeen;
    logic [7:0] warmCnt;
    logic warmLow;
    logic [1:0] divCnt;
    logic busClk;
  } mpb_regs_t;

  mpb_regs_t r_q;
  mpb_regs_t r_d;
  logic coldSync_n;
  logic warmSync_n;
  logic brSync_n;
  logic [mpb_pkg::DATA_W-1:0] dataSync;
  logic coldActive;
  logic warmActive;

  // all pins from outside pass two flops before use
  mpb_sync #(.WIDTH(3), .RESET_VAL(3'h7)) u_ctrlSync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pinIn({cold_reset_n, warmResetIn_n, bus_request_n}),
    .syncOut({coldSync_n, warmSync_n, brSync_n})
  );
  mpb_sync #(.WIDTH(mpb_pkg::DATA_W), .RESET_VAL('0)) u_dataSync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pinIn(busDataIn),
    .syncOut(dataSync)
  );

  // refuse lengths the counters cannot serve; read data reaches the logic two
  // cycles late through the synchroniser, so the strobe must last two cycles
  if (SETUP_LEN == 4'h0 || HOLD_LEN == 4'h0 || WARM_LEN == 8'h00) begin : g_badLen
    $error("bus phase lengths must be at least one cycle");
  end
  if (STROBE_LEN < 4'h2) begin : g_badStrobe
    $error("strobe must last two cycles or more");
  end
  if (mpb_pkg::CS_W > (1 << mpb_pkg::CS_IDX_W)) begin : g_badCs
    $error("chip select index too narrow for the select count");
  end

  // one-hot chip select decode, active low
  function automatic logic [mpb_pkg::CS_W-1:0] csDecode(input logic [mpb_pkg::CS_IDX_W-1:0] idx);
    logic [mpb_pkg::CS_W-1:0] v;
    v = '1;
    if (idx < mpb_pkg::CS_IDX_W'(mpb_pkg::CS_W)) begin
      v[idx] = 1'b0;
    end
    return v;
  endfunction : csDecode

  // a phase counter on its final cycle; a zero count acts as one
  function automatic logic lastCycle(input logic [3:0] cnt);
    return cnt <= 4'h1;
  endfunction : lastCycle

  assign coldActive = ~coldSync_n;
  assign warmActive = (r_q.warmCnt != 8'h00) || ~warmSync_n;

  // next-state logic for the whole port
  always_comb begin
    r_d = r_q;
    r_d.rspV = 1'b0;
    // bus clock divided from the master clock
    if (r_q.divCnt == mpb_pkg::CLK_DIV) begin
      r_d.divCnt = 2'h0;
      r_d.busClk = ~r_q.busClk;
    end else begin
      r_d.divCnt = r_q.divCnt + 2'h1;
    end
    // warm reset held for a fixed span, restarted by a request or a fresh
    // low on the line; the bare line level would re-trigger on our own drive
    r_d.warmLow = ~warmSync_n;
    if (warmResetReq || (~warmSync_n && !r_q.warmLow)) begin
      r_d.warmCnt = WARM_LEN;
    end else if (r_q.warmCnt != 8'h00) begin
      r_d.warmCnt = r_q.warmCnt - 8'h01;
    end
    if (coldActive) begin
      // data pins sampled as the boot vector while cold reset is held
      r_d.boot = dataSync;
      r_d.coldSeen = 1'b1;
      r_d.bootV = 1'b0;
      // cold reset clears the bus state
      r_d.st = mpb_pkg::ST_IDLE;
      r_d.cnt = 4'h0;
    end else begin
      if (r_q.coldSeen) begin
        r_d.bootV = 1'b1;
      end
      case (r_q.st)
        mpb_pkg::ST_IDLE: begin
          if (~brSync_n) begin
            r_d.st = mpb_pkg::ST_RELEASE;
          end else if (reqValid && !warmActive) begin
            r_d.st = mpb_pkg::ST_SETUP;
            r_d.cnt = SETUP_LEN;
            r_d.rd = reqRead;
            r_d.addr = reqAddr;
            r_d.cs = csDecode(reqCs);
            r_d.be = reqByteEn;
            r_d.wdata = reqWData;
          end
        end
        mpb_pkg::ST_SETUP: begin
          if (lastCycle(r_q.cnt)) begin
            r_d.st = mpb_pkg::ST_STROBE;
            r_d.cnt = STROBE_LEN;
          end else begin
            r_d.cnt = r_q.cnt - 4'h1;
          end
        end
        mpb_pkg::ST_STROBE: begin
          if (lastCycle(r_q.cnt)) begin
            r_d.st = mpb_pkg::ST_HOLD;
            r_d.cnt = HOLD_LEN;
          end else begin
            r_d.cnt = r_q.cnt - 4'h1;
          end
        end
        mpb_pkg::ST_HOLD: begin
          // the synchronised pins lag two cycles, so the first hold cycle
          // still shows what the device drove during the strobe
          if (r_q.cnt == HOLD_LEN) begin
            r_d.rdata = dataSync;
          end
          if (lastCycle(r_q.cnt)) begin
            r_d.st = mpb_pkg::ST_IDLE;
            r_d.rspV = 1'b1;
            r_d.cs = '1;
          end else begin
            r_d.cnt = r_q.cnt - 4'h1;
          end
        end
        // one cycle with drivers off before the grant shows
        mpb_pkg::ST_RELEASE: begin
          r_d.st = mpb_pkg::ST_GRANTED;
        end
        mpb_pkg::ST_GRANTED: begin
          // stay off the bus until the request is withdrawn
          if (brSync_n) begin
            r_d.st = mpb_pkg::ST_IDLE;
          end
        end
        default: begin
          r_d.st = mpb_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r_q <= '{st: mpb_pkg::ST_IDLE, cs: '1, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  logic active;
  logic owning;
  logic strobe;
  assign active = (r_q.st == mpb_pkg::ST_SETUP) || (r_q.st == mpb_pkg::ST_STROBE)
                  || (r_q.st == mpb_pkg::ST_HOLD);
  assign strobe = (r_q.st == mpb_pkg::ST_STROBE);
  // the port owns the bus unless released, and never during cold reset
  assign owning = (r_q.st != mpb_pkg::ST_RELEASE) && (r_q.st != mpb_pkg::ST_GRANTED)
                  && !coldActive;

  assign reqReady = (r_q.st == mpb_pkg::ST_IDLE) && brSync_n && !warmActive && !coldActive;
  assign rspValid = r_q.rspV;
  assign rspRData = r_q.rdata;
  assign bootVector = r_q.boot;
  assign bootValid = r_q.bootV;
  // open-drain style drive of the warm reset line
  assign warmResetActive = warmActive;
  assign warmResetOut = 1'b0;
  assign warmResetOe = (r_q.warmCnt != 8'h00);
  assign bus_clock_out = r_q.busClk;
  // low address on dedicated pins, high bits only through alt function
  assign bus_address = r_q.addr[mpb_pkg::ADDR_W-1:0];
  assign busAddrOe = owning;
  assign busAddrHi = r_q.addr[mpb_pkg::ADDR_W+mpb_pkg::ADDR_HI_W-1:mpb_pkg::ADDR_W];
  // each upper pin goes out only while its alternate function is on
  for (genvar i = 0; i < mpb_pkg::ADDR_HI_W; i++) begin : g_addrHi
    assign busAddrHiOe[i] = owning && addrHiAltEn[i];
  end
  // data driven only on writes, never during cold reset
  assign busDataOut = r_q.wdata;
  assign busDataOe = owning && active && !r_q.rd;
  // chip select held through the transfer
  assign chip_select_n = active ? r_q.cs : '1;
  assign read_not_write = active ? r_q.rd : 1'b1;
  // lane enables during the write strobe
  assign byte_write_enable_n = (strobe && !r_q.rd) ? ~r_q.be : '1;
  // device drives during the read strobe
  assign read_output_enable_n = ~(strobe && r_q.rd);
  assign buffer_direction_n = active ? r_q.rd : 1'b0;
  assign buffer_output_enable_n = ~active;
  // strobes and selects released while granted
  assign strobeOe = owning;
  assign bus_grant_n = ~(r_q.st == mpb_pkg::ST_GRANTED);
endmodule : mpb_bus_port

/* test/mpb_bus_port_properties.sv */
`timescale 1ns/100ps
// pin-level checks of the bus port, one clock domain
module mpb_bus_port_properties (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cold_reset_n,
  input wire logic warmResetReq,
  input wire logic warmResetOe,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic reqRead,
  input wire logic [1:0] reqByteEn,
  input wire logic [25:0] reqAddr,
  input wire logic bus_clock_out,
  input wire logic [21:0] bus_address,
  input wire logic [3:0] busAddrHi,
  input wire logic rspValid,
  input wire logic [3:0] addrHiAltEn,
  input wire logic [3:0] busAddrHiOe,
  input wire logic busAddrOe,
  input wire logic busDataOe,
  input wire logic [5:0] chip_select_n,
  input wire logic read_not_write,
  input wire logic [1:0] byte_write_enable_n,
  input wire logic read_output_enable_n,
  input wire logic buffer_direction_n,
  input wire logic buffer_output_enable_n,
  input wire logic strobeOe,
  input wire logic bus_grant_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic take;
  logic [1:0] beQ;
  logic [25:0] addrQ;
  assign take = reqValid && reqReady;
  // lanes and address of the transfer in flight, the request pins may already move on
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      beQ <= 2'h0;
      addrQ <= 26'h0;
    end else if (take) begin
      beQ <= reqByteEn;
      addrQ <= reqAddr;
    end
  end
  AST_ADDR_HOLD: assert property (!buffer_output_enable_n |->
    {busAddrHi, bus_address} == addrQ) else $error("address moved in transfer");
  AST_BUS_CLOCK: assert property ($changed(bus_clock_out) |=> $stable(bus_clock_out)
    ##1 $changed(bus_clock_out)) else $error("bus clock rate");
  AST_READ_STROBE: assert property (take && reqRead |=> read_not_write && !busDataOe
    ##1 (!read_output_enable_n && &byte_write_enable_n)[*2]) else $error("read strobe");
  AST_WRITE_LANES: assert property (take && !reqRead |=> ##1
    (byte_write_enable_n == ~beQ && read_output_enable_n)[*2]) else $error("write lanes");
  AST_WRITE_DIR: assert property (take && !reqRead |=> !read_not_write && busDataOe
    && !buffer_output_enable_n) else $error("write direction");
  AST_BUF_DIR: assert property (!buffer_output_enable_n |->
    buffer_direction_n == read_not_write) else $error("buffer direction");
  AST_ONE_SELECT: assert property ($onehot0(~chip_select_n) &&
    (&chip_select_n || !buffer_output_enable_n)) else $error("chip select");
  AST_ANSWER: assert property (take |-> ##[4:5] rspValid) else $error("no answer");
  AST_GRANT_FREE: assert property (!bus_grant_n |-> !busAddrOe && !strobeOe
    && !busDataOe && !reqReady) else $error("bus kept under grant");
  AST_GRANT_AFTER: assert property ($fell(bus_grant_n) |-> !$past(strobeOe))
    else $error("grant before release");
  AST_ADDR_HI: assert property ($stable(addrHiAltEn) && busAddrOe |->
    busAddrHiOe == addrHiAltEn) else $error("upper address enables");
  AST_COLD_DATA: assert property (!cold_reset_n [*4] |-> !busDataOe)
    else $error("data driven in cold reset");
  AST_WARM_DRIVE: assert property ($rose(warmResetReq) |-> ##[1:4] warmResetOe [*8])
    else $error("warm reset line");
  cover property (take && reqRead);
  cover property (take && !reqRead);
  cover property ($fell(bus_grant_n));
endmodule : mpb_bus_port_properties

bind mpb_bus_port mpb_bus_port_properties u_props (.*);

/* test/mpb_ext_mem.sv */
`timescale 1ns/100ps
// sixteen-word device behind the port; released lines show a changing pattern
module mpb_ext_mem #(
  parameter logic [15:0] BOOT = 16'h5a3c
) (
  input wire logic clk_sys,
  input wire logic cold_reset_n,
  input wire logic [21:0] bus_address,
  input wire logic [5:0] chip_select_n,
  input wire logic read_output_enable_n,
  input wire logic [1:0] byte_write_enable_n,
  input wire logic [15:0] busDataOut,
  input wire logic busDataOe,
  output logic [15:0] busDataIn
);
  logic [15:0] memQ [16];
  logic [15:0] lastQ = 16'h0;
  logic sel;
  assign sel = ~&chip_select_n;
  initial for (int i = 0; i < 16; i++) memQ[i] = 16'h0;
  // wire level: port, boot straps, selected device, else the inverse of last
  always @* begin
    if (busDataOe) busDataIn = busDataOut;
    else if (!cold_reset_n) busDataIn = BOOT;
    else if (sel && !read_output_enable_n) busDataIn = memQ[bus_address[3:0]];
    else busDataIn = ~lastQ;
  end
  // each lane written only under its own enable
  always @(posedge clk_sys) begin
    lastQ <= busDataIn;
    if (sel && !byte_write_enable_n[0]) memQ[bus_address[3:0]][7:0] <= busDataOut[7:0];
    if (sel && !byte_write_enable_n[1]) memQ[bus_address[3:0]][15:8] <= busDataOut[15:8];
  end
endmodule : mpb_ext_mem

/* test/mpb_bus_port_bench.sv */
`timescale 1ns/100ps
// boot capture, random traffic, bus hand-over and warm reset
module mpb_bus_port_bench;
  localparam logic [15:0] BOOT = 16'h5a3c;
  logic clk_sys, rst, cold_reset_n, warmResetIn_n, warmResetOut, warmResetOe, warmResetReq;
  logic warmResetActive, reqValid, reqReady, reqRead, rspValid, bootValid, bus_clock_out;
  logic busAddrOe, busDataOe, read_not_write, read_output_enable_n, buffer_direction_n;
  logic buffer_output_enable_n, strobeOe, bus_request_n, bus_grant_n, warmExt_n;
  logic [25:0] reqAddr;
  logic [21:0] bus_address;
  logic [2:0] reqCs;
  logic [1:0] reqByteEn, byte_write_enable_n;
  logic [3:0] addrHiAltEn, busAddrHi, busAddrHiOe;
  logic [5:0] chip_select_n;
  logic [15:0] reqWData, rspRData, bootVector, busDataIn, busDataOut;
  logic [15:0] shadow [16];
  logic [16:0] q [$];
  logic [16:0] e;
  int errorCnt, comparisons, seed, n;
  mpb_bus_port DUT (.*);
  mpb_ext_mem #(.BOOT(BOOT)) u_mem (.*);
  // warm reset line is pulled up; the port pulls it low through its enable
  assign warmResetIn_n = warmResetOe ? warmResetOut : warmExt_n;
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errorCnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude;
    $display("comparisons %0d errors %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic wait_for(ref logic sig, input logic val, input string what);
    for (int i = 0; i < 40 && sig !== val; i++) @(negedge clk_sys);
    check(what, {15'h0, sig}, {15'h0, val});
    @(posedge clk_sys);
  endtask : wait_for
  // one transfer, held until taken; chip selects cycle through all six
  task automatic xfer(input logic rd);
    logic [3:0] a;
    logic [1:0] be;
    logic [15:0] wd;
    a = 4'($random(seed));
    be = 2'($random(seed));
    wd = 16'($random(seed));
    reqValid <= 1'b1;
    reqRead <= rd;
    reqAddr <= {22'($random(seed)), a};
    reqCs <= 3'(n % 6);
    reqByteEn <= be;
    reqWData <= wd;
    n++;
    if (!rd && be[0]) shadow[a][7:0] = wd[7:0];
    if (!rd && be[1]) shadow[a][15:8] = wd[15:8];
    q.push_back({rd, shadow[a]});
    do @(negedge clk_sys); while (reqReady !== 1'b1);
    @(posedge clk_sys);
  endtask : xfer
  // answers come in request order; write answers carry nothing to compare
  always @(posedge clk_sys) begin
    if (rspValid === 1'b1) begin
      if (q.size() == 0) begin
        check("unexpected answer", 16'h1, 16'h0);
      end else begin
        e = q.pop_front();
        if (e[16]) check("read data", rspRData, e[15:0]);
      end
    end
  end
  initial begin
    #40000;
    errorCnt++;
    conclude();
  end
  initial begin
    seed = 32'hf295099c;
    n = 0;
    {rst, warmExt_n, bus_request_n} = 3'h7;
    cold_reset_n = 1'b0;
    {reqValid, reqRead, warmResetReq, reqAddr, reqCs, reqByteEn, reqWData, addrHiAltEn} = '0;
    for (int i = 0; i < 16; i++) shadow[i] = 16'h0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (8) @(posedge clk_sys);
    cold_reset_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check("boot valid", {15'h0, bootValid}, 16'h1);
    check("boot vector", bootVector, BOOT);
    $display("test boot done");
    addrHiAltEn <= 4'($random(seed));
    repeat (60) xfer(1'($random(seed)));
    reqValid <= 1'b0;
    repeat (8) @(posedge clk_sys);
    $display("test traffic done");
    bus_request_n <= 1'b0;
    wait_for(bus_grant_n, 1'b0, "grant");
    reqValid <= 1'b1;
    repeat (10) @(posedge clk_sys);
    reqValid <= 1'b0;
    bus_request_n <= 1'b1;
    wait_for(bus_grant_n, 1'b1, "grant withdrawn");
    $display("test hand-over done");
    warmResetReq <= 1'b1;
    @(posedge clk_sys);
    warmResetReq <= 1'b0;
    wait_for(warmResetActive, 1'b1, "warm start");
    wait_for(warmResetActive, 1'b0, "warm end");
    warmExt_n <= 1'b0;
    wait_for(warmResetOe, 1'b1, "warm line driven");
    warmExt_n <= 1'b1;
    wait_for(warmResetActive, 1'b0, "warm line end");
    $display("test warm reset done");
    repeat (12) xfer(1'($random(seed)));
    reqValid <= 1'b0;
    repeat (10) @(posedge clk_sys);
    check("pending answers", 16'(q.size()), 16'h0);
    $display("test final traffic done");
    conclude();
  end
endmodule : mpb_bus_port_bench
